// file: hw/clk_mode_ctrl.sv
// Purpose: System clock generator control: speed modes, main oscillator stop,
//          stop mode with timer 1/2 restart delay, and wait mode
// Assumes: Oscillator pins are sampled on core_clk, which is much faster than either
// Notes:   Rules that the block and its software partner keep follow
// How it works
// - Middle speed: main divided by eight, reset default
// - High speed: main divided by two
// - Low speed: sub divided by two
// - Low speed plus bit 5 halts main
// - Sub pins high impedance after power-on
// - Stop holds clock high, halts both oscillators
// - Stop loads timers 1 and 2 from latches
// - Recovery: timer 1 on source/16, cascades timer 2
// - Stop clears timer mode register except bit 4
// - Restart on external interrupt, clock after timer 2 underflow
// - Wait holds clock high, oscillators unchanged
// - Wait ends on any interrupt immediately
// - Latch value n divides by n plus one
`timescale 1ns/1ps
`default_nettype none
module clk_mode_ctrl (
    input  wire logic                  core_clk,
    input  wire logic                  srst,
    input  wire clk_mode_pkg::apb_req_t apb_req,
    output var  clk_mode_pkg::apb_rsp_t apb_rsp,
    input  wire logic                  main_osc_in,
    output logic                       main_osc_out,
    input  wire logic                  sub_osc_in,
    output logic                       sub_osc_out,
    output logic                       sub_osc_out_oe,
    output logic                       main_osc_en,
    output logic                       sub_osc_en,
    input  wire logic                  stop_instruction,
    input  wire logic                  wait_instruction,
    input  wire logic                  ext_irq,
    input  wire logic                  any_irq,
    output logic                       sys_clk_phi,
    output logic                       cpu_clk_en
);
    import clk_mode_pkg::*;

    typedef struct packed {
        clk_state_t  mode;
        logic [1:0]  speed;
        logic        sub_en;
        logic        main_stop;
        logic [7:0]  t123;
        logic [7:0]  lat1;
        logic [7:0]  lat2;
        logic [7:0]  tim1;
        logic [7:0]  tim2;
        logic [3:0]  pre;
        logic [1:0]  div;
        logic        phi;
        logic [2:0]  main_sy;
        logic [2:0]  sub_sy;
        logic        main_out;
        logic        sub_out;
    } st_t;

    st_t  st_r;
    st_t  st_nxt;
    logic main_run;
    logic sub_run;
    logic m_edge;
    logic s_edge;
    logic src_edge;
    logic t1_tick;
    logic apb_acc;
    logic apb_wr;
    logic [2:0] idx;

    // Offset decode: index 0..5 for mapped words, 7 when unmapped
    function automatic logic [2:0] reg_idx(input logic [7:0] a);
        unique case (a)
            OFF_MODE_CTRL: reg_idx = 3'h0;
            OFF_T123_MODE: reg_idx = 3'h1;
            OFF_LATCH1:    reg_idx = 3'h2;
            OFF_LATCH2:    reg_idx = 3'h3;
            OFF_STATUS:    reg_idx = 3'h4;
            OFF_TIMERS:    reg_idx = 3'h5;
            default:       reg_idx = 3'h7;
        endcase
    endfunction : reg_idx

    // Oscillator run enables and edge detection on the second/third sync stages
    assign main_run = (st_r.mode != ST_STOP) && !(st_r.speed == SPD_LOW && st_r.main_stop);
    assign sub_run  = (st_r.mode != ST_STOP) && st_r.sub_en;
    assign m_edge   = main_run && st_r.main_sy[1] && !st_r.main_sy[2];
    assign s_edge   = sub_run && st_r.sub_sy[1] && !st_r.sub_sy[2];
    assign src_edge = (st_r.speed == SPD_LOW) ? s_edge : m_edge;
    assign t1_tick  = (st_r.mode == ST_RECOVER) && src_edge && (st_r.pre == PRESCALE_LAST);
    assign apb_acc  = apb_req.psel && apb_req.penable;
    assign apb_wr   = apb_acc && apb_req.pwrite;
    assign idx      = reg_idx(apb_req.paddr);

    // Next-state logic
    always_comb begin
        st_nxt = st_r;
        st_nxt.main_sy = {st_r.main_sy[1], st_r.main_sy[0], main_osc_in};
        st_nxt.sub_sy  = {st_r.sub_sy[1], st_r.sub_sy[0], sub_osc_in};
        st_nxt.main_out = main_run ? !st_r.main_sy[1] : 1'b1;
        st_nxt.sub_out  = sub_run ? !st_r.sub_sy[1] : 1'b0;

        // Register writes; the timer mode clear at stop entry below overrides a timer mode write
        if (apb_wr) begin
            unique case (idx)
                3'h0: begin
                    if (apb_req.pwdata[SPEED_LSB +: 2] != 2'h3) begin
                        st_nxt.speed = apb_req.pwdata[SPEED_LSB +: 2];
                    end
                    st_nxt.sub_en    = apb_req.pwdata[SUB_EN_BIT];
                    st_nxt.main_stop = apb_req.pwdata[MAIN_STOP_BIT];
                end
                3'h1: st_nxt.t123 = apb_req.pwdata[7:0];
                3'h2: st_nxt.lat1 = apb_req.pwdata[7:0];
                3'h3: st_nxt.lat2 = apb_req.pwdata[7:0];
                default: ;
            endcase
        end

        unique case (st_r.mode)
            ST_RUN: begin
                // Clock generation from the selected oscillator
                if (st_r.speed == SPD_LOW) begin
                    if (s_edge) begin
                        st_nxt.phi = !st_r.phi;
                    end
                end else if (st_r.speed == SPD_HIGH) begin
                    if (m_edge) begin
                        st_nxt.phi = !st_r.phi;
                    end
                end else if (m_edge) begin
                    st_nxt.div = st_r.div + 2'h1;
                    if (st_r.div == MID_HALF_LAST) begin
                        st_nxt.phi = !st_r.phi;
                    end
                end
                if (stop_instruction) begin
                    st_nxt.mode = ST_STOP;
                    st_nxt.phi  = 1'b1;
                    st_nxt.tim1 = st_nxt.lat1;
                    st_nxt.tim2 = st_nxt.lat2;
                    st_nxt.t123 = st_r.t123 & T123_KEEP_MASK;
                    st_nxt.pre  = 4'h0;
                end else if (wait_instruction) begin
                    st_nxt.mode = ST_WAIT;
                    st_nxt.phi  = 1'b1;
                end
            end
            ST_WAIT: begin
                st_nxt.phi = 1'b1;
                if (any_irq) begin
                    st_nxt.mode = ST_RUN;
                end
            end
            ST_STOP: begin
                st_nxt.phi = 1'b1;
                if (ext_irq) begin
                    st_nxt.mode = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                // Prescaler by 16, timer 1 underflow clocks timer 2
                st_nxt.phi = 1'b1;
                if (src_edge) begin
                    st_nxt.pre = st_r.pre + 4'h1;
                end
                if (t1_tick) begin
                    if (st_r.tim1 == 8'h00) begin
                        st_nxt.tim1 = st_r.lat1;
                        if (st_r.tim2 == 8'h00) begin
                            st_nxt.tim2 = st_r.lat2;
                            st_nxt.mode = ST_RUN;
                        end else begin
                            st_nxt.tim2 = st_r.tim2 - 8'h01;
                        end
                    end else begin
                        st_nxt.tim1 = st_r.tim1 - 8'h01;
                    end
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_r.mode      <= ST_RUN;
            st_r.speed     <= SPD_MIDDLE;
            st_r.sub_en    <= 1'b0;
            st_r.main_stop <= 1'b0;
            st_r.t123      <= RST_T123;
            st_r.lat1      <= RST_LATCH1;
            st_r.lat2      <= RST_LATCH2;
            st_r.tim1      <= RST_LATCH1;
            st_r.tim2      <= RST_LATCH2;
            st_r.pre       <= 4'h0;
            st_r.div       <= 2'h0;
            st_r.phi       <= 1'b1;
            st_r.main_sy   <= 3'h0;
            st_r.sub_sy    <= 3'h0;
            st_r.main_out  <= 1'b1;
            st_r.sub_out   <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // APB answer: zero wait states, error on unmapped offsets
    always_comb begin
        apb_rsp.pready  = apb_acc;
        apb_rsp.pslverr = apb_acc && (idx == 3'h7);
        apb_rsp.prdata  = 32'h0000_0000;
        unique case (idx)
            3'h0: begin
                apb_rsp.prdata[SPEED_LSB +: 2]  = st_r.speed;
                apb_rsp.prdata[SUB_EN_BIT]     = st_r.sub_en;
                apb_rsp.prdata[MAIN_STOP_BIT]  = st_r.main_stop;
            end
            3'h1: apb_rsp.prdata[7:0] = st_r.t123;
            3'h2: apb_rsp.prdata[7:0] = st_r.lat1;
            3'h3: apb_rsp.prdata[7:0] = st_r.lat2;
            3'h4: apb_rsp.prdata[6:0] = {st_r.phi, sub_run, main_run,
                                         st_r.mode == ST_RECOVER, st_r.mode == ST_STOP,
                                         st_r.mode == ST_WAIT, st_r.mode == ST_RUN};
            3'h5: apb_rsp.prdata[15:0] = {st_r.tim2, st_r.tim1};
            default: ;
        endcase
    end

    // Pin and core outputs
    assign main_osc_out   = st_r.main_out;
    assign sub_osc_out    = st_r.sub_out;
    assign sub_osc_out_oe = sub_run;
    assign main_osc_en    = main_run;
    assign sub_osc_en     = sub_run;
    assign sys_clk_phi    = st_r.phi;
    assign cpu_clk_en     = (st_r.mode == ST_RUN);

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    // Reset defaults
    chk_reset_middle: assert property (
        $fell(srst) |-> st_r.speed == SPD_MIDDLE && cpu_clk_en)
        else $error("speed not middle after reset");

    chk_sub_hiz_reset: assert property (
        $fell(srst) |-> !sub_osc_out_oe [*2])
        else $error("sub oscillator pin driven after reset");

    chk_sub_out_off: assert property (
        !sub_osc_en |=> !sub_osc_out)
        else $error("sub output moved while sub halted");

    // Clock generation per speed
    chk_mid_toggle: assert property (
        st_r.mode == ST_RUN && st_r.speed == SPD_MIDDLE && m_edge && st_r.div != MID_HALF_LAST
        && !stop_instruction && !wait_instruction |=> $stable(sys_clk_phi))
        else $error("middle speed clock moved early");

    chk_high_toggle: assert property (
        st_r.mode == ST_RUN && st_r.speed == SPD_HIGH && m_edge
        && !stop_instruction && !wait_instruction |=> sys_clk_phi != $past(sys_clk_phi))
        else $error("high speed clock did not follow main edge");

    chk_low_toggle: assert property (
        st_r.mode == ST_RUN && st_r.speed == SPD_LOW && !s_edge
        && !stop_instruction && !wait_instruction |=> $stable(sys_clk_phi))
        else $error("low speed clock moved without sub edge");

    // Main oscillator halt
    chk_low_main_halt: assert property (
        st_r.speed == SPD_LOW && st_r.main_stop |-> !main_osc_en)
        else $error("main oscillator runs while stopped in low speed");

    chk_main_out_idle: assert property (
        !main_osc_en |=> main_osc_out)
        else $error("main output not parked high while halted");

    // Register access
    chk_speed_write: assert property (
        apb_wr && idx == 3'h0 && apb_req.pwdata[SPEED_LSB +: 2] == SPD_HIGH |=> st_r.speed == SPD_HIGH)
        else $error("speed field write lost");

    chk_bad_offset: assert property (
        apb_acc && idx == 3'h7 |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0000_0000)
        else $error("unmapped offset not refused");

    // Stop entry
    chk_stop_halt: assert property (
        st_r.mode == ST_RUN && stop_instruction |=> sys_clk_phi && !main_osc_en && !sub_osc_en)
        else $error("stop entry left clock or oscillator running");

    chk_stop_load: assert property (
        st_r.mode == ST_RUN && stop_instruction && !apb_wr
        |=> st_r.tim1 == $past(st_r.lat1) && st_r.tim2 == $past(st_r.lat2))
        else $error("timers not loaded on stop entry");

    chk_t123_keep: assert property (
        st_r.mode == ST_RUN && stop_instruction |=> (st_r.t123 & ~T123_KEEP_MASK) == 8'h00)
        else $error("timer mode register not cleared on stop");

    // Recovery count and clock gate
    chk_recover_enter: assert property (
        st_r.mode == ST_STOP && ext_irq |=> st_r.mode == ST_RECOVER && !cpu_clk_en)
        else $error("interrupt did not start recovery");

    chk_t1_reload: assert property (
        t1_tick && st_r.tim1 == 8'h00 && !apb_wr |=> st_r.tim1 == $past(st_r.lat1))
        else $error("timer 1 did not reload on underflow");

    chk_t2_exit: assert property (
        t1_tick && st_r.tim1 == 8'h00 && st_r.tim2 == 8'h00 |=> cpu_clk_en)
        else $error("clock withheld after timer 2 underflow");

    chk_recover_gate: assert property (
        st_r.mode inside {ST_STOP, ST_RECOVER} |-> !cpu_clk_en && sys_clk_phi)
        else $error("clock reached core before timer 2 underflow");

    // Wait mode
    chk_wait_osc: assert property (
        st_r.mode == ST_RUN && wait_instruction && !stop_instruction && !apb_wr
        |=> main_osc_en == $past(main_osc_en) && sub_osc_en == $past(sub_osc_en) && sys_clk_phi)
        else $error("wait changed oscillator state");

    chk_wait_hold: assert property (
        st_r.mode == ST_WAIT |-> sys_clk_phi && !cpu_clk_en)
        else $error("clock moved during wait");

    chk_wait_exit: assert property (
        st_r.mode == ST_WAIT && any_irq |=> cpu_clk_en)
        else $error("wait exit delayed");

    // Main scenarios reached
    cov_stop_recover: cover property (st_r.mode == ST_RECOVER ##1 st_r.mode == ST_RUN);
    cov_wait_exit: cover property (st_r.mode == ST_WAIT ##1 st_r.mode == ST_RUN);
    cov_low_main_off: cover property (st_r.speed == SPD_LOW && !main_osc_en);
    cov_high_clock: cover property (st_r.speed == SPD_HIGH && sys_clk_phi ##1 !sys_clk_phi);
    cov_bad_offset: cover property (apb_rsp.pslverr);

endmodule : clk_mode_ctrl
`default_nettype wire

// file: hw/clk_mode_pkg.sv
// Purpose: Shared constants and types for the system clock mode control block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   Speed encoding and register layout are local to this block
package clk_mode_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_MODE_CTRL = 8'h00;
    localparam logic [7:0] OFF_T123_MODE = 8'h04;
    localparam logic [7:0] OFF_LATCH1    = 8'h08;
    localparam logic [7:0] OFF_LATCH2    = 8'h0C;
    localparam logic [7:0] OFF_STATUS    = 8'h10;
    localparam logic [7:0] OFF_TIMERS    = 8'h14;

    // Mode control field positions
    localparam int SPEED_LSB     = 0;
    localparam int SUB_EN_BIT    = 4;
    localparam int MAIN_STOP_BIT = 5;

    // Speed select encodings
    localparam logic [1:0] SPD_MIDDLE = 2'h0;
    localparam logic [1:0] SPD_HIGH   = 2'h1;
    localparam logic [1:0] SPD_LOW    = 2'h2;

    // Timers 1-2-3 mode register: only this bit survives stop entry
    localparam logic [7:0] T123_KEEP_MASK = 8'h10;

    // Reset values
    localparam logic [7:0] RST_T123   = 8'h00;
    localparam logic [7:0] RST_LATCH1 = 8'hFF;
    localparam logic [7:0] RST_LATCH2 = 8'h01;

    // Timing counts in oscillator edges
    localparam logic [1:0] MID_HALF_LAST = 2'h3;  // Divide by 8: toggle every 4 edges
    localparam logic [3:0] PRESCALE_LAST = 4'hF;  // Divide by 16 in recovery

    typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_STOP, ST_RECOVER} clk_state_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

endpackage : clk_mode_pkg

// file: tb/osc_model.sv
// Purpose: Resonator model for the main and sub oscillator pins
// Assumes: Half periods are counted in core_clk cycles
// Notes:   A halted resonator holds its last level
`timescale 1ns/1ps
`default_nettype none
module osc_model #(
    parameter int MAIN_HALF = 4,
    parameter int SUB_HALF  = 20
) (
    input  wire logic core_clk,
    input  wire logic main_en,
    input  wire logic sub_en,
    output var  logic main_in,
    output var  logic sub_in
);
    int mc = 0;
    int sc = 0;
    initial main_in = 1'b0;
    initial sub_in = 1'b0;
    // Main runs five times faster than sub
    always @(posedge core_clk) begin
        if (main_en) begin
            mc <= (mc == MAIN_HALF - 1) ? 0 : mc + 1;
            if (mc == MAIN_HALF - 1) main_in <= ~main_in;
        end
        // Sub stands still until enabled
        if (sub_en) begin
            sc <= (sc == SUB_HALF - 1) ? 0 : sc + 1;
            if (sc == SUB_HALF - 1) sub_in <= ~sub_in;
        end
    end
endmodule : osc_model
`default_nettype wire

// file: tb/system_clock_mode_control_test.sv
// Purpose: Self-checking bench for the clock mode control block
// Assumes: Zero wait state APB slave, oscillators from osc_model
// Notes:   Phi periods are measured in core_clk cycles
`timescale 1ns/1ps
`default_nettype none
module system_clock_mode_control_test;
    import clk_mode_pkg::*;
    localparam logic [7:0]  ADDRS [7] = '{OFF_MODE_CTRL, OFF_T123_MODE, OFF_LATCH1, OFF_LATCH2,
                                           OFF_STATUS, OFF_TIMERS, 8'h18};
    localparam logic [31:0] RVALS [7] = '{32'h0, 32'h0, 32'hFF, 32'h1, 32'h51, 32'h1FF, 32'h0};
    localparam int          EXP_PER [3] = '{64, 16, 80};
    logic        core_clk = 1'b0;
    logic        srst     = 1'b1;
    apb_req_t    req      = '0;
    apb_rsp_t    rsp;
    logic        main_in, main_out, sub_in, sub_out, sub_oe, main_en, sub_en, phi, cpu_en;
    logic        stop_instr = 1'b0;
    logic        wait_instr = 1'b0;
    logic        ext_irq  = 1'b0;
    logic        any_irq  = 1'b0;
    int          miscompares = 0;
    int          n_checks    = 0;
    int          cycles      = 0;
    int          per;
    int          n;
    logic [31:0] rd;
    logic        er;

    clk_mode_ctrl u_clk_mode_ctrl (.core_clk(core_clk), .srst(srst), .apb_req(req), .apb_rsp(rsp),
        .main_osc_in(main_in), .main_osc_out(main_out), .sub_osc_in(sub_in), .sub_osc_out(sub_out),
        .sub_osc_out_oe(sub_oe), .main_osc_en(main_en), .sub_osc_en(sub_en),
        .stop_instruction(stop_instr), .wait_instruction(wait_instr), .ext_irq(ext_irq), .any_irq(any_irq),
        .sys_clk_phi(phi), .cpu_clk_en(cpu_en));
    osc_model u_osc_model (.core_clk(core_clk), .main_en(main_en), .sub_en(sub_en),
        .main_in(main_in), .sub_in(sub_in));

    // 50 MHz core clock
    always #10 core_clk = ~core_clk;

    // Cycle ceiling against hangs
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge core_clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
        @(posedge core_clk);
        req.penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req <= '0;
    endtask : apb

    // Cycles between two rising edges of phi
    task automatic measure(output int p);
        int   t0;
        int   i;
        logic prev;
        t0 = -1;
        p = 0;
        prev = phi;
        for (i = 0; i < 2000 && p == 0; i++) begin
            @(posedge core_clk);
            if (phi === 1'b1 && prev === 1'b0) begin
                if (t0 < 0) t0 = i;
                else p = i - t0;
            end
            prev = phi;
        end
    endtask : measure

    // Core pulse of one cycle: 0 stop, 1 wait, 2 external irq, 3 any irq
    task automatic pulse(input int sel);
        @(posedge core_clk);
        case (sel)
            0: stop_instr <= 1'b1;
            1: wait_instr <= 1'b1;
            2: ext_irq <= 1'b1;
            default: any_irq <= 1'b1;
        endcase
        @(posedge core_clk);
        {stop_instr, wait_instr, ext_irq, any_irq} <= 4'h0;
        @(posedge core_clk);
    endtask : pulse

    initial begin
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        // Reset values and an unmapped offset
        for (n = 0; n < 7; n++) begin
            apb(1'b0, ADDRS[n], 32'h0);
            chk(rd, RVALS[n]);
            chk(32'(er), 32'(n == 6));
        end
        chk(32'({sub_out, sub_oe, sub_en, main_en}), 32'h1);
        $display("test reset done");
        // Speed modes with both oscillators running
        apb(1'b1, OFF_MODE_CTRL, 32'h10);
        repeat (200) @(posedge core_clk);
        for (n = 0; n < 3; n++) begin
            apb(1'b1, OFF_MODE_CTRL, 32'h10 | n);
            measure(per);
            measure(per);
            chk(32'(per), 32'(EXP_PER[n]));
        end
        apb(1'b1, OFF_MODE_CTRL, 32'h13);
        apb(1'b0, OFF_MODE_CTRL, 32'h0);
        chk(rd, 32'h12);
        $display("test speed done");
        // Main halt in low speed, then restart and settle
        apb(1'b1, OFF_MODE_CTRL, 32'h32);
        repeat (2) @(posedge core_clk);
        chk(32'({main_en, main_out}), 32'h1);
        apb(1'b1, OFF_MODE_CTRL, 32'h12);
        repeat (200) @(posedge core_clk);
        apb(1'b1, OFF_MODE_CTRL, 32'h10);
        $display("test main stop done");
        // Stop mode: restart count of 16 x 2 x 2 main edges
        apb(1'b1, OFF_LATCH1, 32'h1);
        apb(1'b1, OFF_LATCH2, 32'h1);
        apb(1'b1, OFF_T123_MODE, 32'hFF);
        pulse(0);
        chk(32'({phi, cpu_en, main_en, sub_en}), 32'h8);
        apb(1'b0, OFF_TIMERS, 32'h0);
        chk(rd, 32'h101);
        apb(1'b0, OFF_T123_MODE, 32'h0);
        chk(rd, 32'h10);
        pulse(2);
        n = 0;
        while (cpu_en !== 1'b1 && n < 1000) begin
            @(posedge core_clk);
            n++;
        end
        chk(32'(n >= 500 && n <= 560), 32'h1);
        $display("test stop done");
        // Wait mode keeps both oscillators and ends at once
        pulse(1);
        repeat (20) @(posedge core_clk);
        chk(32'({phi, cpu_en, main_en, sub_en}), 32'hB);
        pulse(3);
        chk(32'(cpu_en), 32'h1);
        $display("test wait done");
        stop_test();
    end
endmodule : system_clock_mode_control_test
`default_nettype wire
